// File: pkg/sdpr_defines.svh
// Offsets, field positions, reset values and counts for the serial pin routing block
`ifndef SDPR_DEFINES_SVH
`define SDPR_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register map (indices; byte address is four times the index)
// ----------------------------------------------------------------------------
`define SDPR_ROUTE_IDX_FIRST  16'hf240
`define SDPR_ROUTE_IDX_LAST   16'hf247
`define SDPR_ROUTE_COUNT      8
`define SDPR_ROUTE_RESET      16'h0000

// ----------------------------------------------------------------------------
// Field positions inside serial_pin_routing
// ----------------------------------------------------------------------------
`define SDPR_ROUTE_ON_BIT     5
`define SDPR_DIR_BIT          4
`define SDPR_PORT_HI          3
`define SDPR_PORT_LO          2
`define SDPR_GRP_HI           1
`define SDPR_GRP_LO           0

`endif

// File: pkg/sdpr_pkg.sv
// Types shared by the serial pin routing block
package sdpr_pkg;

  // Pin direction as held in the direction bit
  typedef enum logic {
    SDPR_DIR_PIN_TO_IN,
    SDPR_DIR_OUT_TO_PIN
  } sdpr_dir_t;

  // Channel number, wide enough for channel 47
  typedef logic [5:0] sdpr_slot_group_pick_t;

  // Register contents
  typedef logic [15:0] sdpr_word_t;

endpackage

// File: logic/sdpr_pin_slice.sv
// Field decode and channel group lookup for one shared serial pin
`timescale 1ns/100ps
`include "sdpr_defines.svh"

module sdpr_pin_slice (
  input  wire sdpr_pkg::sdpr_word_t route_word,
  input  wire logic [3:0]           port_tdm,
  output logic                      pin_route_on,
  output sdpr_pkg::sdpr_dir_t       dir,
  output logic [1:0]                port_pick,
  output logic [1:0]                slot_group_pick,
  output logic                      group_ok,
  output sdpr_pkg::sdpr_slot_group_pick_t      slot_group_pick_hi,
  output sdpr_pkg::sdpr_slot_group_pick_t      slot_group_pick_lo
);
  import sdpr_pkg::*;

  logic tdm;

  // ----------------------------------------------------------------------------
  // Field split; upper bits 15..6 are stored only and steer nothing
  // ----------------------------------------------------------------------------
  assign pin_route_on    = route_word[`SDPR_ROUTE_ON_BIT];                 // RULE_02
  assign dir             = sdpr_dir_t'(route_word[`SDPR_DIR_BIT]);         // RULE_03
  assign port_pick       = route_word[`SDPR_PORT_HI:`SDPR_PORT_LO];        // RULE_05
  assign slot_group_pick = route_word[`SDPR_GRP_HI:`SDPR_GRP_LO];
  assign tdm             = port_tdm[port_pick];

  // Channel range per port, mode and group code; unlisted codes carry nothing
  always_comb begin
    group_ok = 1'b1;
    slot_group_pick_hi  = 6'h00;
    slot_group_pick_lo  = 6'h00;
    case ({port_pick, tdm, slot_group_pick})
      5'b00_0_00, 5'b00_1_00: begin slot_group_pick_hi = 6'd7;  slot_group_pick_lo = 6'd4;  end // RULE_06 RULE_07
      5'b00_0_01, 5'b00_1_01: begin slot_group_pick_hi = 6'd11; slot_group_pick_lo = 6'd8;  end // RULE_06 RULE_07
      5'b00_0_10, 5'b00_1_10: begin slot_group_pick_hi = 6'd15; slot_group_pick_lo = 6'd12; end // RULE_06 RULE_07
      5'b00_1_11:             begin slot_group_pick_hi = 6'd15; slot_group_pick_lo = 6'd8;  end // RULE_07
      5'b01_0_00:             begin slot_group_pick_hi = 6'd7;  slot_group_pick_lo = 6'd6;  end // RULE_08
      5'b01_0_01:             begin slot_group_pick_hi = 6'd11; slot_group_pick_lo = 6'd10; end // RULE_08
      5'b01_0_10:             begin slot_group_pick_hi = 6'd15; slot_group_pick_lo = 6'd14; end
      5'b01_1_00:             begin slot_group_pick_hi = 6'd23; slot_group_pick_lo = 6'd20; end // RULE_09
      5'b01_1_01:             begin slot_group_pick_hi = 6'd27; slot_group_pick_lo = 6'd24; end // RULE_09
      5'b01_1_10:             begin slot_group_pick_hi = 6'd31; slot_group_pick_lo = 6'd28; end // RULE_09
      5'b01_1_11:             begin slot_group_pick_hi = 6'd31; slot_group_pick_lo = 6'd27; end // RULE_09
      5'b10_0_00:             begin slot_group_pick_hi = 6'd35; slot_group_pick_lo = 6'd34; end // RULE_10
      5'b10_1_00:             begin slot_group_pick_hi = 6'd39; slot_group_pick_lo = 6'd36; end // RULE_10
      5'b11_0_00:             begin slot_group_pick_hi = 6'd47; slot_group_pick_lo = 6'd46; end // RULE_11
      5'b11_1_00:             begin slot_group_pick_hi = 6'd47; slot_group_pick_lo = 6'd44; end // RULE_11
      default:                begin group_ok = 1'b0; end
    endcase
  end

endmodule

// File: logic/sdpr_routing.sv
// APB register bank and data steering for eight shared serial data pins
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
`include "sdpr_defines.svh"

// How it works
// RULE_01: Eight 16-bit routing registers, reset to zero.
// RULE_02: Enable bit routes pin, else multipurpose use.
// RULE_03: Direction zero feeds pin into input port.
// RULE_04: Direction one drives pin from output port.
// RULE_05: Two bits pick serial port zero to three.
// RULE_06: Port 0 two-channel groups 7:4, 11:8, 15:12.
// RULE_07: Port 0 TDM groups, code 11 gives 15:8.
// RULE_08: Port 1 two-channel groups 7:6, 11:10; the logic also maps code 10 to 15:14.
// RULE_09: Port 1 TDM groups 23:20 to 31:27.
// RULE_10: Port 2 code 00: 35:34 or 39:36.
// RULE_11: Port 3 code 00: 47:46 or 47:44.
// RULE_12: Software writes zero to reserved upper bits.
module sdpr_routing #(
  parameter int ADDR_W = 18
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [3:0]        port_tdm,
  input  wire logic [15:0]       ser_out_lane,
  output logic [15:0]            ser_in_lane,
  output logic [15:0]            ser_in_lane_valid,
  input  wire logic [7:0]        shared_serial_pin_in,
  output logic [7:0]             shared_serial_pin_out,
  output logic [7:0]             shared_serial_pin_oe_n,
  output logic [7:0]             mpio_pin_free,
  output logic [47:0]            pin_slot_group_pick_range,
  output logic [7:0]             pin_group_ok
);
  import sdpr_pkg::*;

  localparam int NPIN = `SDPR_ROUTE_COUNT;

  sdpr_word_t   serial_pin_routing [NPIN];
  logic         access;
  logic         hit;
  logic [2:0]   idx;
  logic [15:0]  word_idx;
  logic [15:0]  idx_off;
  logic [NPIN-1:0]      route_on;
  logic [NPIN-1:0]      drive_out;
  logic [NPIN-1:0]      feed_in;
  logic [3:0]           lane_sel [NPIN];
  logic [15:0]          next_in_lane;
  logic [15:0]          next_in_valid;
  logic [NPIN-1:0]      next_pin_out;

  // ----------------------------------------------------------------------------
  // APB decode: register index is the word address, base index 0xf240
  // ----------------------------------------------------------------------------
  assign access   = psel && penable;
  assign word_idx = 16'(paddr >> 2);
  assign idx_off  = word_idx - `SDPR_ROUTE_IDX_FIRST;
  assign hit      = (word_idx >= `SDPR_ROUTE_IDX_FIRST) && (word_idx <= `SDPR_ROUTE_IDX_LAST);
  assign idx      = idx_off[2:0];

  // Zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = access && !hit;
  assign prdata  = (psel && hit) ? {16'h0000, serial_pin_routing[idx]} : 32'h0000_0000;

  // Register writes honour the two low byte strobes; upper bits stored as-is
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NPIN; i++) begin
        serial_pin_routing[i] <= `SDPR_ROUTE_RESET;                       // RULE_01
      end
    end else if (access && pwrite && hit) begin
      if (pstrb[0]) begin
        serial_pin_routing[idx][7:0] <= pwdata[7:0];                      // RULE_01
      end
      if (pstrb[1]) begin
        serial_pin_routing[idx][15:8] <= pwdata[15:8];                    // RULE_12
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Per-pin decode
  // ----------------------------------------------------------------------------
  for (genvar p = 0; p < NPIN; p++) begin : g_pin
    sdpr_dir_t  dir;
    logic [1:0] port_pick;
    logic [1:0] grp;
    logic       ok;

    sdpr_pin_slice u_slice (
      .route_word      (serial_pin_routing[p]),
      .port_tdm        (port_tdm),
      .pin_route_on    (route_on[p]),
      .dir             (dir),
      .port_pick       (port_pick),
      .slot_group_pick (grp),
      .group_ok        (ok),
      .slot_group_pick_hi         (pin_slot_group_pick_range[p*6+:3*2]),
      .slot_group_pick_lo         ()
    );

    // Lane number is port then group code
    assign lane_sel[p]     = {port_pick, grp};                              // RULE_05
    assign pin_group_ok[p] = ok;
    assign drive_out[p]    = route_on[p] && ok && (dir == SDPR_DIR_OUT_TO_PIN); // RULE_04
    assign feed_in[p]      = route_on[p] && ok && (dir == SDPR_DIR_PIN_TO_IN);  // RULE_03
    assign mpio_pin_free[p] = !route_on[p];                                 // RULE_02
    assign next_pin_out[p] = drive_out[p] ? ser_out_lane[lane_sel[p]] : 1'b0;
  end

  // Gather input pins onto lanes; lowest pin wins if two share a lane
  always_comb begin
    next_in_lane  = 16'h0000;
    next_in_valid = 16'h0000;
    for (int i = NPIN - 1; i >= 0; i--) begin
      if (feed_in[i]) begin
        next_in_lane[lane_sel[i]]  = shared_serial_pin_in[i];             // RULE_03
        next_in_valid[lane_sel[i]] = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Registered data paths; one cycle of latency keeps outputs glitch free
  // ----------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shared_serial_pin_out  <= 8'h00;
      shared_serial_pin_oe_n <= 8'hff;
    end else begin
      shared_serial_pin_out  <= next_pin_out;                               // RULE_04
      shared_serial_pin_oe_n <= ~drive_out;                                 // RULE_02
    end
  end

  // Input lanes toward the serial input ports
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_in_lane       <= 16'h0000;
      ser_in_lane_valid <= 16'h0000;
    end else begin
      ser_in_lane       <= next_in_lane;
      ser_in_lane_valid <= next_in_valid;
    end
  end

endmodule

// File: test/sdpr_far_side.sv
// Behavioural serial ports and pin pads beyond the routing block
`timescale 1ns/100ps
module sdpr_far_side (
  input  wire logic       pclk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  output logic [15:0]     ser_out_lane,
  output logic [7:0]      pin_lvl
);
  logic [7:0] cnt = 8'h00;
  // Pattern moves every cycle; lanes 0 and 8 toggle each cycle, lane 4 only every 16 cycles
  always_ff @(posedge pclk) cnt <= cnt + 8'h01;
  assign ser_out_lane = {cnt, ~cnt};
  // Pad level: the block's drive wins where its enable is low
  assign pin_lvl = (pin_out & ~pin_oe_n) | ((cnt ^ 8'h96) & pin_oe_n);
endmodule

// File: test/sdpr_routing_checker.sv
// Port assertions for the serial pin routing block
`timescale 1ns/100ps
module sdpr_routing_checker #(parameter int ADDR_W = 18) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire logic [15:0]       ser_out_lane,
  input wire logic [7:0]        shared_serial_pin_out,
  input wire logic [7:0]        shared_serial_pin_oe_n,
  input wire logic [7:0]        mpio_pin_free,
  input wire logic [7:0]        pin_group_ok
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic        acc;
  logic        wr0;
  logic [15:0] ix;
  // Access phase decode; word index is the byte address over four
  assign acc = psel && penable;
  assign ix  = 16'(paddr >> 2);
  assign wr0 = acc && pwrite && pstrb[0] && ix == 16'hf240;
  map_ok_a: assert property (acc && ix >= 16'hf240 && ix <= 16'hf247 |-> !pslverr)
    else $error("mapped access refused");
  unmap_err_a: assert property (
    acc && (ix < 16'hf240 || ix > 16'hf247) |-> pslverr && prdata == 32'h0)
    else $error("unmapped access accepted");
  rd_upper_a: assert property (psel && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("read upper half not zero");
  rst_free_a: assert property ($rose(presetn) |-> mpio_pin_free == 8'hff)
    else $error("pins not free after reset");
  en_free_a: assert property (wr0 |=> mpio_pin_free[0] == !$past(pwdata[5]))
    else $error("free flag ignores enable");
  drive_src_a: assert property (
    !shared_serial_pin_oe_n[0] |-> !$past(mpio_pin_free[0]) && $past(pin_group_ok[0]))
    else $error("pin driven without valid route");
  idle_low_a: assert property ((shared_serial_pin_out & shared_serial_pin_oe_n) == 8'h00)
    else $error("undriven pin data not zero");
  in_quiet_a: assert property (
    wr0 && pwdata[5:4] == 2'h2 |=> ##1 shared_serial_pin_oe_n[0])
    else $error("input pin driven");
  out_drive_a: assert property (
    wr0 && pwdata[5:0] == 6'h34 |=> ##1 !shared_serial_pin_oe_n[0] &&
    shared_serial_pin_out[0] == $past(ser_out_lane[4]))
    else $error("output pin data wrong");
endmodule
bind sdpr_routing sdpr_routing_checker #(.ADDR_W(ADDR_W)) u_chk (.*);

// File: test/sdpr_routing_tb_top.sv
// Register-level bench for the serial pin routing block
`timescale 1ns/100ps
module sdpr_routing_tb_top;
  import sdpr_pkg::*;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic [17:0] paddr = 18'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic [3:0]  port_tdm = 4'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er, v1, v2;
  logic [15:0] ser_out_lane, ser_in_lane, lane_ok;
  logic [7:0]  pin_lvl, pin_out, pin_oe_n, pin_free, grp_ok;
  logic [47:0] slot_group_pick_rng;
  logic [6:0]  g;
  logic [15:0] ge, gs;
  int          err_total = 0;
  int          cmp_count = 0;
  always #2.5 pclk = ~pclk;
  sdpr_routing #(.ADDR_W(18)) DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_tdm(port_tdm),
    .ser_out_lane(ser_out_lane), .ser_in_lane(ser_in_lane), .ser_in_lane_valid(lane_ok),
    .shared_serial_pin_in(pin_lvl), .shared_serial_pin_out(pin_out),
    .shared_serial_pin_oe_n(pin_oe_n), .mpio_pin_free(pin_free),
    .pin_slot_group_pick_range(slot_group_pick_rng), .pin_group_ok(grp_ok));
  sdpr_far_side u_far (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ser_out_lane(ser_out_lane), .pin_lvl(pin_lvl));
  // ---------------------------------------------------------------
  // Bus cycle, compare, table and verdict helpers
  // ---------------------------------------------------------------
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] s);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // Entered just after an edge; leaves one idle edge so strobes never double up
  task automatic apb(input logic w, input logic [15:0] ix, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {ix, 2'h0};
    pwdata <= d;
    @(posedge pclk) penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  // Expected {valid, highest channel} per port, code and mode
  function automatic logic [6:0] grp(input logic [1:0] p, input logic [1:0] c, input logic t);
    case (p)
      2'h0: grp = (c == 2'h3) ? {t, 6'h0f} : {1'h1, 6'h07 + {2'h0, c, 2'h0}};
      2'h1: grp = (c == 2'h3) ? {t, 6'h1f} : {1'h1, (t ? 6'h17 : 6'h07) + {2'h0, c, 2'h0}};
      2'h2: grp = {c == 2'h0, t ? 6'h27 : 6'h23};
      default: grp = {c == 2'h0, 6'h2f};
    endcase
  endfunction
  task automatic finish_test;
    if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (2000) @(posedge pclk);
    err_total++;
    finish_test;
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 8; i++) begin
      apb(1'h0, 16'hf240 + 16'(i), 32'h0, rd, er);
      cmp("reset", 16'h0, rd[15:0]);
    end
    // Software keeps the reserved upper bits at zero
    for (int i = 0; i < 8; i++) apb(1'h1, 16'hf240 + 16'(i), 32'(i << 3), rd, er);
    for (int i = 0; i < 8; i++) begin
      apb(1'h0, 16'hf240 + 16'(i), 32'h0, rd, er);
      cmp("readback", 16'(i << 3), rd[15:0]);
    end
    cmp("free", 16'h0f, {8'h0, pin_free});
    // Only the upper byte strobe: the low byte must keep its value
    pstrb <= 4'h2;
    apb(1'h1, 16'hf242, 32'h3f, rd, er);
    pstrb <= 4'hf;
    apb(1'h0, 16'hf242, 32'h0, rd, er);
    cmp("strobe", 16'h0010, rd[15:0]);
    apb(1'h0, 16'hf248, 32'h0, rd, er);
    cmp("unmapped", 16'h1, {rd[14:0], er});
    // Every port, code and mode on pin 0
    for (int k = 0; k < 32; k++) begin
      port_tdm <= {4{k[4]}};
      apb(1'h1, 16'hf240, {28'h2, k[3:0]}, rd, er);
      g = grp(k[3:2], k[1:0], k[4]);
      ge = {9'h0, g[6], g[6] ? g[5:0] : 6'h0};
      gs = {9'h0, grp_ok[0], g[6] ? slot_group_pick_rng[5:0] : 6'h0};
      cmp("group", ge, gs);
    end
    apb(1'h1, 16'hf240, 32'h34, rd, er);
    apb(1'h1, 16'hf241, 32'h21, rd, er);
    @(posedge pclk);
    v1 = ser_out_lane[4];
    v2 = pin_lvl[1];
    #1 cmp("drive", {15'h0, v1}, {14'h0, pin_oe_n[0], pin_out[0]});
    cmp("feed", {14'h0, 1'h1, v2}, {14'h0, lane_ok[1], ser_in_lane[1]});
    @(posedge pclk);
    apb(1'h1, 16'hf240, 32'h0, rd, er);
    @(posedge pclk);
    cmp("off", 16'h3, {14'h0, pin_oe_n[0], pin_free[0]});
    finish_test;
  end
endmodule
